// ### rtl/tarb_top.v
// PCM receive double buffer, port translation, arbiter, command bus and LEDs
`timescale 1ns/1ns
`include "tarb_defines.vh"
module tarb_top #(
  parameter TS_W    = 8,                     // Timeslot address width
  parameter PORT_W  = 5                      // DSP port address width
) (
  input  wire              SYS_CLK,          // 10 MHz system clock
  input  wire              RST,              // Synchronous reset, active high
  input  wire              FRAME_SYNC,       // Backplane frame signal, async
  input  wire [TS_W-1:0]   PCM_TS,           // Current backplane timeslot
  input  wire [7:0]        PCM_DATA,         // Backplane PCM byte
  input  wire              PCM_STB,          // Sample valid strobe, sync
  input  wire              DSP_RD,           // DSP port read strobe
  input  wire [PORT_W-1:0] DSP_PORT,         // DSP port address
  output reg  [7:0]        DSP_DATA,         // PCM byte to DSP
  output reg               DSP_ACK,          // Read data valid pulse
  output reg               DSP_IRQ,          // One-cycle frame interrupt
  input  wire              SER_WR,           // Serial setup write request
  input  wire [PORT_W-1:0] SER_PORT,         // Serial setup port
  input  wire [TS_W-1:0]   SER_TS,           // Serial setup timeslot
  output reg               SER_DONE,         // Serial write done pulse
  input  wire              PKT_WR,           // Packet processor setup write
  input  wire [PORT_W-1:0] PKT_PORT,         // Packet processor setup port
  input  wire [TS_W-1:0]   PKT_TS,           // Packet processor setup timeslot
  output reg               PKT_DONE,         // Packet setup done pulse
  input  wire              PKT_DSP_SEL,      // Packet processor accesses DSP
  output reg               PKT_CLK_SLOW,     // Slow the packet processor clock
  input  wire              CMD_VALID,        // Command bus cycle strobe
  input  wire              CMD_TYPE,         // 0 individual, 1 broadcast
  input  wire [7:0]        CMD_ADDR,         // Card address or card type
  input  wire              CMD_ALL,          // Broadcast to all card types
  input  wire [7:0]        CARD_ADDR,        // This card's slot address
  input  wire [7:0]        CARD_TYPE,        // This card's type code
  output reg               CMD_ACCEPT,       // Cycle taken by this card
  output reg               CMD_REPLY_EN,     // Card may answer (individual)
  input  wire              LED_WR,           // Indicator register write
  input  wire [2:0]        LED_DIN,          // Bits: 2 red, 1 yellow, 0 green
  output reg  [2:0]        LED_N             // Indicators, active low
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Frame memory is plain flops indexed by {half, timeslot}
  reg [7:0]      frame_mem [0:2*`TARB_NUM_TS-1];   // Two frames
  reg [TS_W-1:0] setup_mem [0:`TARB_NUM_PORTS-1];  // Path setup RAM
  reg [2:0]      fs_sync_q;
  reg            half_q;
  reg            fs_lvl_q;                         // Frame level last taken
  reg [2:0]      slow_q;
  reg            dsp_pend_q, ser_pend_q, pkt_pend_q;
  wire [2:0]     gnt;
  wire           fs_rise;
  integer        i;

  // Frame signal rise counts once stages two and three agree on a high level
  // not yet taken; a pulse shorter than two clocks is filtered out as a glitch
  assign fs_rise = fs_sync_q[1] & fs_sync_q[2] & ~fs_lvl_q;

  // Frame memory index: half select above the timeslot
  function [8:0] mem_idx;
    input            half;
    input [TS_W-1:0] ts;
    begin
      mem_idx = {half, ts};
    end
  endfunction

  // A port has a setup entry only below the channel count; higher addresses
  // are refused rather than folded onto a real channel
  function port_ok;
    input [PORT_W-1:0] port;
    begin
      port_ok = (port < `TARB_NUM_PORTS);
    end
  endfunction

  // ----------------------------------------------------------------
  // Frame sync and buffer swap
  // ----------------------------------------------------------------
  // Three stage synchroniser; stage 1 feeds only stage 2. The taken level
  // follows stage 3 only while stages 2 and 3 agree, so one rise gives one swap
  always @(posedge SYS_CLK) begin
    if (RST) begin
      fs_sync_q <= 3'h0;
      half_q    <= 1'b0;
      DSP_IRQ   <= 1'b0;
      fs_lvl_q  <= 1'b0;
    end else begin
      fs_sync_q <= {fs_sync_q[1:0], FRAME_SYNC};
      DSP_IRQ   <= 1'b0;
      if (fs_sync_q[1] == fs_sync_q[2])
        fs_lvl_q <= fs_sync_q[2];
      if (fs_rise) begin
        half_q  <= ~half_q;
        DSP_IRQ <= 1'b1;
      end
    end
  end

  // Capture into the half the DSP is not reading
  // No reset on the store: stale bytes can reach the DSP only in the first frame
  always @(posedge SYS_CLK) begin
    if (PCM_STB)
      frame_mem[mem_idx(half_q, PCM_TS)] <= PCM_DATA;
  end

  // ----------------------------------------------------------------
  // Setup RAM requesters
  // ----------------------------------------------------------------
  // Each requester holds its request until served for one cycle
  tarb_arbiter u_arb (
    .clk   (SYS_CLK),
    .rst   (RST),
    .req   ({dsp_pend_q & ~gnt[2], pkt_pend_q & ~gnt[1], ser_pend_q & ~gnt[0]}),
    .gnt_q (gnt)
  );

  // Pending flags: a new strobe in the grant cycle is kept, set wins
  // A request leaves the arbiter while granted, so each grant lasts one cycle
  always @(posedge SYS_CLK) begin
    if (RST) begin
      ser_pend_q <= 1'b0;
      pkt_pend_q <= 1'b0;
      dsp_pend_q <= 1'b0;
      SER_DONE   <= 1'b0;
      PKT_DONE   <= 1'b0;
      DSP_ACK    <= 1'b0;
      DSP_DATA   <= 8'h00;
    end else begin
      SER_DONE   <= gnt[0];
      PKT_DONE   <= gnt[1];
      DSP_ACK    <= gnt[2];
      ser_pend_q <= SER_WR | (ser_pend_q & ~gnt[0]);
      pkt_pend_q <= PKT_WR | (pkt_pend_q & ~gnt[1]);
      dsp_pend_q <= DSP_RD | (dsp_pend_q & ~gnt[2]);
      if (gnt[2]) begin
        // Port to timeslot, then stored byte of the finished half; a port
        // past the last channel has no setup entry and reads as zero
        if (port_ok(DSP_PORT))
          DSP_DATA <= frame_mem[mem_idx(~half_q, setup_mem[DSP_PORT])];
        else
          DSP_DATA <= 8'h00;
      end
    end
  end

  // Only the serial path and the packet processor may write setups
  // Grants are one-hot, so the two write ports never meet in one cycle
  always @(posedge SYS_CLK) begin
    if (RST) begin
      for (i = 0; i < `TARB_NUM_PORTS; i = i + 1)
        setup_mem[i] <= {TS_W{1'b0}};
    end else if (gnt[0] && port_ok(SER_PORT)) begin
      setup_mem[SER_PORT] <= SER_TS;
    end else if (gnt[1] && port_ok(PKT_PORT)) begin
      setup_mem[PKT_PORT] <= PKT_TS;
    end
  end
  // A port read takes three cycles, so 24 reads fit many times into a frame

  // ----------------------------------------------------------------
  // Packet processor slow cycles
  // ----------------------------------------------------------------
  // Fixed stretch keeps the slow DSP side inside the processor's window
  // The countdown starts only once select drops, so long accesses stay slow
  always @(posedge SYS_CLK) begin
    if (RST) begin
      slow_q       <= 3'h0;
      PKT_CLK_SLOW <= 1'b0;
    end else begin
      if (PKT_DSP_SEL)
        slow_q <= `TARB_SLOW_CYC;
      else if (slow_q != 3'h0)
        slow_q <= slow_q - 3'h1;
      PKT_CLK_SLOW <= PKT_DSP_SEL | (slow_q > 3'h1);
    end
  end

  // ----------------------------------------------------------------
  // Command bus decode and indicators
  // ----------------------------------------------------------------
  // Decode runs every cycle; a card that misses its address stays silent,
  // so individual replies never collide on the shared command bus
  always @(posedge SYS_CLK) begin
    if (RST) begin
      CMD_ACCEPT   <= 1'b0;
      CMD_REPLY_EN <= 1'b0;
      LED_N        <= `TARB_LED_RESET;
    end else begin
      CMD_ACCEPT   <= 1'b0;
      CMD_REPLY_EN <= 1'b0;
      if (CMD_VALID) begin
        if (CMD_TYPE == `TARB_CYC_INDIV && CMD_ADDR == CARD_ADDR) begin
          CMD_ACCEPT   <= 1'b1;
          CMD_REPLY_EN <= 1'b1;
        end else if (CMD_TYPE == `TARB_CYC_BCAST && (CMD_ALL || CMD_ADDR == CARD_TYPE)) begin
          CMD_ACCEPT   <= 1'b1;
        end
      end
      if (LED_WR)
        LED_N <= LED_DIN;
    end
  end
endmodule // tarb_top

// ### rtl/tarb_defines.vh
// Constants for the tone analyzer PCM receive buffer and setup RAM arbiter
`ifndef TARB_DEFINES_VH
`define TARB_DEFINES_VH
`define TARB_FRAME_US        125
`define TARB_CLK_MHZ         10
`define TARB_FRAME_CYC       (`TARB_FRAME_US * `TARB_CLK_MHZ)
`define TARB_NUM_PORTS       24
`define TARB_NUM_TS          256
`define TARB_SLOW_CYC        3'h4
`define TARB_LED_RESET       3'h7
`define TARB_REQ_SER         0
`define TARB_REQ_PKT         1
`define TARB_REQ_DSP         2
`define TARB_CYC_INDIV       1'h0
`define TARB_CYC_BCAST       1'h1
`endif

// ### rtl/tarb_arbiter.v
// Fixed-priority request/grant arbiter for the shared path setup RAM
`timescale 1ns/1ns
`include "tarb_defines.vh"
module tarb_arbiter (
  input  wire       clk,     // System clock
  input  wire       rst,     // Synchronous reset, active high
  input  wire [2:0] req,     // Requests: 0 serial setup, 1 packet proc, 2 DSP
  output reg  [2:0] gnt_q    // One-hot grant, held while request stays
);
  reg [2:0] gnt_d;

  // ----------------------------------------------------------------
  // Grant selection
  // ----------------------------------------------------------------
  // A holder keeps the RAM until it drops its request; a new grant only
  // goes out when nobody holds it, so an access is never cut short.
  always @* begin
    gnt_d = gnt_q;
    if ((gnt_q & req) == 3'h0) begin
      gnt_d = 3'h0;
      if (req[`TARB_REQ_SER])
        gnt_d = 3'h1;
      else if (req[`TARB_REQ_PKT])
        gnt_d = 3'h2;
      else if (req[`TARB_REQ_DSP])
        gnt_d = 3'h4;
    end
  end

  // Grant register
  always @(posedge clk) begin
    if (rst)
      gnt_q <= 3'h0;
    else
      gnt_q <= gnt_d;
  end
endmodule // tarb_arbiter

// ### bench/tarb_pcm_src.sv
// Backplane PCM source model: slots, sample bytes and frame signal
`timescale 1ns/1ns
module tarb_pcm_src (
  input  wire       clk,    // System clock
  input  wire       rst,    // Sync reset, active high
  output reg  [7:0] ts_q,   // Current timeslot
  output reg  [7:0] frm_q,  // Frame count
  output wire [7:0] data,   // Byte of this slot
  output wire       sync    // Frame signal
);
  // Free-running slots; the frame count steps as slot 0 begins
  always @(posedge clk) begin
    ts_q  <= rst ? 8'h00 : ts_q + 8'h01;
    frm_q <= rst ? 8'h00 : frm_q + {7'h00, ts_q == 8'hFF};
  end
  // Frame level rises as slot 0 begins and holds for half a frame, long
  // enough to pass the receiver's three-stage glitch filter
  assign sync = ~ts_q[7];
  // Byte depends on frame too, so reading the wrong half shows up
  assign data = ts_q + frm_q * 8'h35;
endmodule // tarb_pcm_src

// ### bench/tarb_checker.sv
// Assertions on the receive buffer top ports
`timescale 1ns/1ns
module tarb_checker (
  input wire       SYS_CLK,       // System clock
  input wire       RST,           // Synchronous reset, active high
  input wire       FRAME_SYNC,    // Backplane frame signal
  input wire       DSP_RD,        // DSP port read strobe
  input wire       DSP_ACK,       // Read data valid pulse
  input wire       DSP_IRQ,       // Frame interrupt
  input wire       SER_WR,        // Serial setup write request
  input wire       PKT_WR,        // Packet setup write request
  input wire       SER_DONE,      // Serial write done pulse
  input wire       PKT_DONE,      // Packet write done pulse
  input wire       PKT_DSP_SEL,   // Packet processor on the DSP
  input wire       PKT_CLK_SLOW,  // Slow clock request
  input wire       CMD_VALID,     // Command cycle strobe
  input wire       CMD_TYPE,      // 0 individual, 1 broadcast
  input wire       CMD_ALL,       // Broadcast to all card types
  input wire       CMD_ACCEPT,    // Cycle taken by this card
  input wire       CMD_REPLY_EN,  // Card may answer
  input wire       LED_WR,        // Indicator write
  input wire [7:0] CMD_ADDR,      // Card address or card type
  input wire [7:0] CARD_ADDR,     // This card's address
  input wire [7:0] CARD_TYPE,     // This card's type
  input wire [2:0] LED_DIN,       // Indicator bits
  input wire [2:0] LED_N          // Indicators, active low
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // Indicators, frame interrupt, arbitration, slow clock and command cycles
  led_load_a: assert property (LED_WR |=> LED_N == $past(LED_DIN)) else $error("led");
  led_reset_a: assert property ($fell(RST) |-> LED_N == 3'h7) else $error("led rst");
  irq_frame_a: assert property ($rose(FRAME_SYNC) |-> ##[2:5] DSP_IRQ) else $error("irq");
  ser_first_a: assert property (SER_WR && PKT_WR |-> ##3 SER_DONE && !PKT_DONE) else $error("prio");
  dsp_ack_a: assert property (DSP_RD && !SER_WR && !PKT_WR |-> ##[3:5] DSP_ACK) else $error("ack");
  slow_on_a: assert property ($rose(PKT_DSP_SEL) |-> ##[0:2] PKT_CLK_SLOW) else $error("slow");
  indiv_cmd_a: assert property (CMD_VALID && !CMD_TYPE && CMD_ADDR == CARD_ADDR
    |=> CMD_ACCEPT && CMD_REPLY_EN) else $error("indiv");
  bcast_cmd_a: assert property (CMD_VALID && CMD_TYPE && (CMD_ALL || CMD_ADDR == CARD_TYPE)
    |=> CMD_ACCEPT && !CMD_REPLY_EN) else $error("bcast");
  irq_pulse_a: assert property (DSP_IRQ |=> !DSP_IRQ) else $error("irq width");
  one_grant_a: assert property ($onehot0({SER_DONE, PKT_DONE, DSP_ACK})) else $error("grant");
  tie_c: cover property (SER_WR && PKT_WR);
  irq_c: cover property (DSP_IRQ);
  read_c: cover property (DSP_ACK);
  bcast_c: cover property (CMD_ACCEPT && !CMD_REPLY_EN);
endmodule // tarb_checker
bind tarb_top tarb_checker chk_u (.SYS_CLK, .RST, .FRAME_SYNC, .DSP_RD, .DSP_ACK, .DSP_IRQ, .SER_WR, .PKT_WR,
  .SER_DONE, .PKT_DONE, .PKT_DSP_SEL, .PKT_CLK_SLOW, .CMD_VALID, .CMD_TYPE, .CMD_ALL, .CMD_ACCEPT,
  .CMD_REPLY_EN, .LED_WR, .CMD_ADDR, .CARD_ADDR, .CARD_TYPE, .LED_DIN, .LED_N);

// ### bench/tarb_top_tb_top.sv
// Self-checking bench for the PCM receive buffer and setup arbiter
`timescale 1ns/1ns
module tarb_top_tb_top;
  reg        clk = 1'b0, rst = 1'b1, rd = 1'b0, swr = 1'b0, pwr = 1'b0, sel = 1'b0;
  reg        cv = 1'b0, ct = 1'b0, ca = 1'b0, lw = 1'b0;
  reg  [4:0] rp = 5'h00, sp = 5'h00, pp = 5'h00;
  reg  [7:0] st = 8'h00, pt = 8'h00, cad = 8'h00;
  reg  [2:0] ld = 3'h0;
  reg  [7:0] map [0:23];
  wire [7:0] ts, frm, pd, dd;
  wire [2:0] ln;
  wire       sync, ack, irq, sdn, pdn, slow, acc, rep;
  integer    err_count = 0, check_count = 0, seed = 32'h8175, i, k;
  tarb_pcm_src pcm_u (.clk(clk), .rst(rst), .ts_q(ts), .frm_q(frm), .data(pd), .sync(sync));
  tarb_top dut_u (.SYS_CLK(clk), .RST(rst), .FRAME_SYNC(sync), .PCM_TS(ts), .PCM_DATA(pd), .PCM_STB(!rst),
    .DSP_RD(rd), .DSP_PORT(rp), .DSP_DATA(dd), .DSP_ACK(ack), .DSP_IRQ(irq), .SER_WR(swr), .SER_PORT(sp),
    .SER_TS(st), .SER_DONE(sdn), .PKT_WR(pwr), .PKT_PORT(pp), .PKT_TS(pt), .PKT_DONE(pdn),
    .PKT_DSP_SEL(sel), .PKT_CLK_SLOW(slow), .CMD_VALID(cv), .CMD_TYPE(ct), .CMD_ADDR(cad), .CMD_ALL(ca),
    .CARD_ADDR(8'h2C), .CARD_TYPE(8'h07), .CMD_ACCEPT(acc), .CMD_REPLY_EN(rep), .LED_WR(lw),
    .LED_DIN(ld), .LED_N(ln));
  function [7:0] pcm_exp(input [7:0] f, input [7:0] t);
    pcm_exp = t + f * 8'h35;
  endfunction
  task chk(input logic ok);
    check_count = check_count + 1;
    if (ok !== 1'b1) begin
      err_count = err_count + 1;
      $display("[ERR] %0t check %0d", $time, check_count);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Both setup sources strike at once, so every pair is a contest
  task setup_pair(input [4:0] p);
    @(posedge clk);
    swr <= 1'b1;
    pwr <= 1'b1;
    sp  <= p;
    pp  <= p + 5'h01;
    st  <= map[p];
    pt  <= map[p+1];
    @(posedge clk);
    swr <= 1'b0;
    pwr <= 1'b0;
    for (k = 0; k < 8 && pdn !== 1'b1; k = k + 1) @(posedge clk) #1;
    chk(pdn);
  endtask
  // Port read must return the slot byte of the frame just finished
  task dsp_read(input [4:0] p);
    @(posedge clk);
    rd <= 1'b1;
    rp <= p;
    @(posedge clk);
    rd <= 1'b0;
    for (k = 0; k < 8 && ack !== 1'b1; k = k + 1) @(posedge clk) #1;
    chk(ack === 1'b1 && dd === pcm_exp(frm - 8'h01, map[p]));
  endtask
  initial forever #50 clk = ~clk;
  // Run needs about 640 cycles; give up well past that
  initial begin
    #1000000;
    err_count = err_count + 1;
    test_done;
  end
  initial begin
    for (i = 0; i < 24; i = i + 1) map[i] = 8'h08 + 8'({$random(seed)} % 248);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) #1;
    chk(ln === 3'h7);
    // Every indicator pattern, command kinds with matching and random addresses
    for (i = 0; i < 40; i = i + 1) begin
      @(posedge clk);
      cv  <= 1'b1;
      lw  <= 1'b1;
      ct  <= i[0];
      ca  <= (i % 5 == 0);
      ld  <= i[2:0];
      cad <= (i % 3 == 0) ? (i[0] ? 8'h07 : 8'h2C) : 8'($random(seed));
      @(posedge clk);
      cv <= 1'b0;
      lw <= 1'b0;
      #1;
      chk(ln === i[2:0]);
      chk(acc === (ct ? (ca || cad == 8'h07) : cad == 8'h2C) && rep === (!ct && cad == 8'h2C));
    end
    for (i = 0; i < 24; i = i + 2) setup_pair(i[4:0]);
    // Two frames in a row prove the halves swap
    repeat (2) begin
      for (k = 0; k < 600 && irq !== 1'b1; k = k + 1) @(posedge clk) #1;
      chk(irq);
      for (i = 0; i < 24; i = i + 1) dsp_read(i[4:0]);
    end
    @(posedge clk);
    sel <= 1'b1;
    repeat (3) @(posedge clk);
    sel <= 1'b0;
    #1;
    chk(slow === 1'b1);
    repeat (9) @(posedge clk);
    #1;
    chk(slow === 1'b0);
    test_done;
  end
endmodule // tarb_top_tb_top
